// [hdl/strap_config_sampler.sv]
// Notes on behaviour
// - Straps undriven while system reset low.
// - Capture strap levels at reset release.
// - Drive straps normally after reset release.
// - Flow control strap: 0 off, 1 on.
// - Link-up strap 0 fast, 1 normal.
// - Normal link-up decodes auto-negotiation pair.
// - Fast link-up: full duplex, master/MDI select.
// - Fast link-up second strap picks PHY speed.
// - Management select: MDIO, I2C, else SPI.
// - Start strap 0 holds forwarding until set.
// - Port 6 interface mode decode.
// - Port 6 role: PHY/clock-out or MAC/clock-in.
// - Port 6 speed: 0 gigabit, 1 10/100.
// - In-band management strap: 0 off, 1 on.
// - Clock wiring strap, readable and software writable.
// - Receive clock pin use per wiring mode.
// - Interrupt open drain, active low.
// - Power event on energy detect, programmable polarity.
// - Indicator outputs are active low.
module strap_config_sampler
    import strap_pkg::*;
#(
    parameter int NPORTS = 5
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 sys_reset_n,
    input  wire logic [STRAP_W-1:0]   strap_in,
    input  wire logic [STRAP_W-1:0]   strap_func_out,
    output logic      [STRAP_W-1:0]   strap_out,
    output logic      [STRAP_W-1:0]   strap_oe,
    input  wire logic                 sw_start_set,
    input  wire logic                 sw_clk_wiring_we,
    input  wire logic                 sw_clk_wiring_wdata,
    output logic                      p6_ctrl0_bit0,
    output cfg_s                      cfg,
    output logic                      cfg_valid,
    output logic                      forward_en,
    input  wire logic                 gmii_rx_clk_src,
    input  wire logic                 mii_rx_clk_src,
    output logic                      p6_rx_clk_pin_out,
    output logic                      p6_rx_clk_pin_oe,
    output logic                      p6_rx_er_is_clk_in,
    input  wire logic                 irq_pending,
    output logic                      irq_out_n_out,
    output logic                      irq_out_n_oe,
    input  wire logic                 energy_detect,
    input  wire logic                 power_event_active_high,
    output logic                      power_event_out,
    input  wire logic [2*NPORTS-1:0]  led_on,
    output logic      [2*NPORTS-1:0]  led_n
);

    typedef struct packed {
        logic               rst_m_q;
        logic               rst_s_q;
        logic [STRAP_W-1:0] strap_m_q;
        logic [STRAP_W-1:0] strap_s_q;
        phase_e             phase_q;
        cfg_store_s         store_q;
        logic               valid_q;
        logic               started_q;
        logic               pme_q;
        logic               irq_q;
        logic [2*NPORTS-1:0] led_n_q;
    } state_s;

    state_s s_q;
    state_s s_d;

    function automatic mgmt_e mgmt_decode(input logic [1:0] v);
        if (v[1]) begin
            return MGMT_SPI;
        end
        return v[0] ? MGMT_I2C : MGMT_MDIO;
    endfunction

    always_comb begin
        s_d           = s_q;
        // Two-stage sync on the pin-level reset and the strap levels
        s_d.rst_m_q   = sys_reset_n;
        s_d.rst_s_q   = s_q.rst_m_q;
        s_d.strap_m_q = strap_in;
        s_d.strap_s_q = s_q.strap_m_q;
        case (s_q.phase_q)
            ST_IN_RESET: begin
                if (s_q.rst_s_q) begin
                    // Straps are sampled in the same cycle the release is seen
                    s_d.store_q.raw        = s_q.strap_s_q;
                    s_d.store_q.clk_wiring = s_q.strap_s_q[B_CLK_WIRING];
                    s_d.valid_q            = 1'b1;
                    s_d.started_q          = s_q.strap_s_q[B_SWITCH_START];
                    s_d.phase_q            = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!s_q.rst_s_q) begin
                    s_d.phase_q   = ST_IN_RESET;
                    s_d.valid_q   = 1'b0;
                    s_d.started_q = 1'b0;
                end else begin
                    if (sw_start_set) begin
                        s_d.started_q = 1'b1;
                    end
                    if (sw_clk_wiring_we) begin
                        s_d.store_q.clk_wiring = sw_clk_wiring_wdata;
                    end
                end
            end
            default: begin
                s_d.phase_q = ST_IN_RESET;
            end
        endcase
        s_d.pme_q   = energy_detect ? power_event_active_high : ~power_event_active_high;
        s_d.irq_q   = irq_pending;
        s_d.led_n_q = ~led_on;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q             <= '0;
            s_q.phase_q     <= ST_IN_RESET;
            s_q.store_q.raw <= STRAP_DEFAULT;
            s_q.store_q.clk_wiring <= STRAP_DEFAULT[B_CLK_WIRING];
            s_q.pme_q       <= 1'b1;
            s_q.led_n_q     <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    logic [STRAP_W-1:0] r;
    logic               running;
    assign r       = s_q.store_q.raw;
    assign running = (s_q.phase_q == ST_RUN);

    // Pins float for the pulls until release, then carry their normal job
    assign strap_oe  = running ? '1 : '0;
    assign strap_out = running ? strap_func_out : '0;

    always_comb begin
        cfg                    = '0;
        cfg.flow_ctrl_en       = r[B_FLOW_CTRL];
        cfg.fast_linkup        = ~r[B_LINKUP_MODE];
        if (r[B_LINKUP_MODE]) begin
            cfg.auto_mdix_en = 1'b1;
            case ({r[B_LINK_CFG_A], r[B_LINK_CFG_B]})
                AN_ENABLED:  cfg.autoneg_en  = 1'b1;
                AN_NAND:     cfg.nand_tree   = 1'b1;
                AN_DISABLED: cfg.autoneg_en  = 1'b0;
                AN_RESERVED: cfg.an_reserved = 1'b1;
                default:     cfg.an_reserved = 1'b1;
            endcase
        end else begin
            cfg.full_duplex_forced = 1'b1;
            cfg.gig_master         = r[B_LINK_CFG_A];
            cfg.mdix_forced        = ~r[B_LINK_CFG_A];
            cfg.gig_speed          = ~r[B_LINK_CFG_B];
        end
        cfg.mgmt_mode    = mgmt_decode({r[B_MGMT_SEL_HI], r[B_MGMT_SEL_LO]});
        cfg.switch_start = r[B_SWITCH_START];
        cfg.p6_iface     = p6_iface_e'({r[B_P6_IFACE_HI], r[B_P6_IFACE_LO]});
        // Role has no meaning in RGMII, so both role outputs stay low there
        if (cfg.p6_iface != P6_RGMII) begin
            cfg.p6_mac_mode = r[B_P6_ROLE];
            cfg.p6_rmii_clk_out = (cfg.p6_iface == P6_RMII) && !r[B_P6_ROLE];
        end
        cfg.p6_gig      = ~r[B_P6_SPEED];
        cfg.inband_mgmt = r[B_INBAND_MGMT];
        cfg.three_wire  = s_q.store_q.clk_wiring;
    end

    assign cfg_valid     = s_q.valid_q;
    assign forward_en    = s_q.started_q;
    assign p6_ctrl0_bit0 = s_q.store_q.clk_wiring;

    // Receive clock pin: 2-wire muxes GMII/MII, 3-wire GMII only
    always_comb begin
        p6_rx_clk_pin_out  = 1'b0;
        p6_rx_clk_pin_oe   = 1'b0;
        p6_rx_er_is_clk_in = 1'b0;
        if (running) begin
            if (cfg.three_wire) begin
                p6_rx_clk_pin_out  = gmii_rx_clk_src;
                p6_rx_clk_pin_oe   = cfg.p6_gig;
                p6_rx_er_is_clk_in = cfg.p6_mac_mode;
            end else begin
                p6_rx_clk_pin_out = cfg.p6_gig ? gmii_rx_clk_src : mii_rx_clk_src;
                p6_rx_clk_pin_oe  = cfg.p6_gig || !cfg.p6_mac_mode;
            end
        end
    end

    // Open drain: only ever pulls low, never drives high
    assign irq_out_n_out   = 1'b0;
    assign irq_out_n_oe    = s_q.irq_q;
    assign power_event_out = s_q.pme_q;
    assign led_n           = s_q.led_n_q;

endmodule

// [hdl/strap_pkg.sv]
package strap_pkg;

    // Strap pin positions in the shared strap bus
    localparam int STRAP_W          = 13;
    localparam int B_FLOW_CTRL      = 0;
    localparam int B_LINKUP_MODE    = 1;
    localparam int B_LINK_CFG_A     = 2;
    localparam int B_LINK_CFG_B     = 3;
    localparam int B_MGMT_SEL_HI    = 4;
    localparam int B_MGMT_SEL_LO    = 5;
    localparam int B_SWITCH_START   = 6;
    localparam int B_P6_IFACE_HI    = 7;
    localparam int B_P6_IFACE_LO    = 8;
    localparam int B_P6_ROLE        = 9;
    localparam int B_P6_SPEED       = 10;
    localparam int B_INBAND_MGMT    = 11;
    localparam int B_CLK_WIRING     = 12;

    // Weak internal pull defaults, used until the first capture
    localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 13'h007F;

    localparam logic [1:0] AN_RESERVED = 2'h0;
    localparam logic [1:0] AN_DISABLED = 2'h1;
    localparam logic [1:0] AN_NAND     = 2'h2;
    localparam logic [1:0] AN_ENABLED  = 2'h3;

    typedef enum logic [1:0] {MGMT_MDIO, MGMT_I2C, MGMT_SPI} mgmt_e;
    typedef enum logic [1:0] {P6_RGMII, P6_RMII, P6_GMII_MII, P6_MII} p6_iface_e;
    typedef enum logic [1:0] {ST_IN_RESET, ST_RUN} phase_e;

    typedef struct packed {
        logic       flow_ctrl_en;
        logic       fast_linkup;
        logic       autoneg_en;
        logic       auto_mdix_en;
        logic       nand_tree;
        logic       an_reserved;
        logic       full_duplex_forced;
        logic       gig_master;
        logic       mdix_forced;
        logic       gig_speed;
        mgmt_e      mgmt_mode;
        logic       switch_start;
        p6_iface_e  p6_iface;
        logic       p6_mac_mode;
        logic       p6_rmii_clk_out;
        logic       p6_gig;
        logic       inband_mgmt;
        logic       three_wire;
    } cfg_s;

    typedef struct packed {
        logic [STRAP_W-1:0] raw;
        logic               clk_wiring;
    } cfg_store_s;

endpackage

// [tb/board_pulls.sv]
module board_pulls
    import strap_pkg::*;
(
    input  wire logic [STRAP_W-1:0] pulls,
    input  wire logic [STRAP_W-1:0] strap_out,
    input  wire logic [STRAP_W-1:0] strap_oe,
    output logic      [STRAP_W-1:0] strap_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin settles to the board pull, never to its last driven value
    always_comb begin
        for (int i = 0; i < STRAP_W; i++) begin
            strap_in[i] = strap_oe[i] ? strap_out[i] : pulls[i];
        end
    end
endmodule

// [tb/strap_config_sampler_asserts.sv]
module strap_checker
    import strap_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               sys_reset_n,
    input wire logic [STRAP_W-1:0] strap_oe,
    input wire logic               sw_start_set,
    input wire logic               sw_clk_wiring_we,
    input wire logic               sw_clk_wiring_wdata,
    input wire logic               p6_ctrl0_bit0,
    input wire cfg_s               cfg,
    input wire logic               cfg_valid,
    input wire logic               forward_en,
    input wire logic               irq_pending,
    input wire logic               irq_out_n_out,
    input wire logic               irq_out_n_oe,
    input wire logic [9:0]         led_on,
    input wire logic [9:0]         led_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff rst;
    a_straps_hiz: assert property (!cfg_valid |-> strap_oe == '0)
        else $error("straps driven before capture");
    a_straps_drive: assert property (cfg_valid |-> &strap_oe)
        else $error("straps not driven after capture");
    a_capture_time: assert property ($rose(sys_reset_n) |-> ##[2:3] cfg_valid)
        else $error("capture late after reset release");
    a_cfg_held: assert property (cfg_valid && $past(cfg_valid)
        |-> $stable({cfg.flow_ctrl_en, cfg.mgmt_mode, cfg.p6_iface}))
        else $error("captured settings changed");
    a_fast_link: assert property (cfg.fast_linkup
        |-> !cfg.autoneg_en && !cfg.auto_mdix_en && cfg.full_duplex_forced)
        else $error("fast link-up left negotiation on");
    a_start_set: assert property (cfg_valid && sw_start_set |=> forward_en)
        else $error("start bit did not enable forwarding");
    a_wiring_write: assert property (cfg_valid && sw_clk_wiring_we
        |=> p6_ctrl0_bit0 == $past(sw_clk_wiring_wdata) && cfg.three_wire == p6_ctrl0_bit0)
        else $error("clock wiring write lost");
    a_irq_drain: assert property (!$past(rst) |-> !irq_out_n_out && irq_out_n_oe == $past(irq_pending))
        else $error("interrupt pin not open drain");
    a_led_low: assert property (!$past(rst) |-> led_n == ~$past(led_on))
        else $error("indicator outputs not active low");
endmodule
bind strap_config_sampler strap_checker u_chk (.*);

// [tb/test_strap_config_sampler.sv]
module test_strap_config_sampler
    import strap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [12:0] p; logic [11:0] e; logic [10:0] x;} row_s;
    // Board straps keep MII/RMII at 10/100 and 3-wire only with MAC mode
    row_s rows [5] = '{'{13'h004F, 12'h059, 11'h023}, '{13'h0F2A, 12'h282, 11'h420},
                       '{13'h12D7, 12'hD1F, 11'h027}, '{13'h05B0, 12'h5A0, 11'h1C2},
                       '{13'h0503, 12'h090, 11'h03A}};
    logic clk, rst, sys_reset_n, sw_start_set, sw_clk_wiring_we, sw_clk_wiring_wdata;
    logic irq_pending, energy_detect, power_event_active_high, gmii_rx_clk_src, mii_rx_clk_src;
    logic p6_ctrl0_bit0, cfg_valid, forward_en, irq_out_n_out, irq_out_n_oe, power_event_out;
    logic p6_rx_clk_pin_out, p6_rx_clk_pin_oe, p6_rx_er_is_clk_in;
    logic [STRAP_W-1:0] pulls, strap_in, strap_out, strap_oe, strap_func_out;
    logic [9:0]         led_on, led_n;
    cfg_s               cfg;
    logic [11:0]        got_cfg;
    logic [10:0]        got_ext;
    int                 mismatches = 0, samples_checked = 0, cycles = 0;
    assign got_cfg = {p6_rx_er_is_clk_in, cfg.mgmt_mode, cfg.p6_iface, cfg.autoneg_en, cfg.fast_linkup,
                      cfg.flow_ctrl_en, forward_en, cfg.nand_tree, cfg.p6_mac_mode, cfg.p6_gig};
    assign got_ext = {cfg.inband_mgmt, cfg.gig_master, cfg.mdix_forced, cfg.gig_speed, cfg.full_duplex_forced,
                      cfg.auto_mdix_en, cfg.an_reserved, cfg.p6_rmii_clk_out, cfg.three_wire,
                      p6_rx_clk_pin_oe, p6_rx_clk_pin_out};
    strap_config_sampler #(.NPORTS(5)) uut (.*);
    board_pulls pull_model (.*);
    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Start pulse lands in the reset phase, where it must be ignored
    task cap(input logic [STRAP_W-1:0] p);
        pulls = p;
        sys_reset_n = 0;
        repeat (4) @(negedge clk);
        sw_start_set = 1;
        @(negedge clk);
        sw_start_set = 0;
        check(strap_oe, 0);
        check(strap_in, p);
        sys_reset_n = 1;
        repeat (8) if (!cfg_valid) @(negedge clk);
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        {rst, sys_reset_n, sw_start_set, sw_clk_wiring_we, sw_clk_wiring_wdata} = 5'h10;
        {irq_pending, energy_detect, power_event_active_high, gmii_rx_clk_src, mii_rx_clk_src} = 5'h02;
        pulls = 0;
        led_on = 0;
        strap_func_out = 13'h0A5A;
        repeat (6) @(negedge clk);
        check({cfg_valid, forward_en, power_event_out, led_n}, {3'h1, 10'h3FF});
        rst = 0;
        foreach (rows[i]) begin
            cap(rows[i].p);
            check(got_cfg, rows[i].e);
            check(got_ext, rows[i].x);
            check(cfg_valid, 1);
            check(strap_oe, 13'h1FFF);
            strap_func_out = ~rows[i].p;
            repeat (4) @(negedge clk);
            check(strap_in, strap_func_out);
            check(got_cfg, rows[i].e);
            $display("strap row %0d done", i);
        end
        sw_start_set = 1;
        @(negedge clk);
        sw_start_set = 0;
        check(forward_en, 1);
        {sw_clk_wiring_we, sw_clk_wiring_wdata} = 2'h3;
        @(negedge clk);
        sw_clk_wiring_we = 0;
        check({p6_ctrl0_bit0, cfg.three_wire}, 2'h3);
        {irq_pending, energy_detect} = 2'h3;
        led_on = 10'h2B5;
        repeat (2) @(negedge clk);
        check({irq_out_n_out, irq_out_n_oe, power_event_out, led_n}, {3'h2, ~10'h2B5});
        power_event_active_high = 1;
        repeat (2) @(negedge clk);
        check(power_event_out, 1);
        $display("side outputs done");
        tally_and_finish;
    end
endmodule
